// ===== hw/gain_switch_pkg.sv
package gain_switch_pkg;
  localparam logic [15:0] GAIN_SWITCH_SELECTION_OFFSET = 16'h2139;
  localparam logic [15:0] SWITCH_WAIT_ONE_OFFSET = 16'h2135;
  localparam logic [15:0] SWITCH_WAIT_TWO_OFFSET = 16'h2136;
  localparam logic [15:0] SWITCH_RAMP_ONE_OFFSET = 16'h2131;
  localparam logic [15:0] SWITCH_RAMP_TWO_OFFSET = 16'h2132;
  localparam logic [15:0] GAIN_SET_A_BASE = 16'h2200;
  localparam logic [15:0] GAIN_SET_B_BASE = 16'h2210;
  localparam logic [15:0] ACTIVE_STATUS_OFFSET = 16'h2220;
  localparam logic [15:0] ACTIVE_GAIN_BASE = 16'h2230;
  localparam int MODE_LSB = 0;
  localparam int COND_LSB = 4;
  localparam logic [3:0] MODE_AUTO = 4'h2;
  localparam logic [15:0] SELECTION_RESET = 16'h0000;
  localparam logic [15:0] TIME_RESET = 16'h0000;
  localparam int NUM_GAINS = 5;
  localparam logic [15:0] GAIN_RESET [5] = '{16'h0190, 16'h07d0, 16'h0190, 16'h0064, 16'h0064};
  localparam int CLOCK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
  typedef enum logic [2:0] {COND_DONE_ON, COND_DONE_OFF, COND_NEAR_ON, COND_NEAR_OFF,
    COND_REF_IDLE, COND_REF_ACTIVE} cond_code_t;
endpackage

// ===== hw/ms_tick.sv
`timescale 1ns/100ps
module ms_tick #(
  parameter int CYCLES = gain_switch_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  output logic tick
);
  logic [31:0] count;
  if (CYCLES < 1)
  begin : g_bad_cycles
    $error("tick period too short");
  end
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      count <= 32'h0000_0000;
    else if (count == 32'(CYCLES - 1))
      count <= 32'h0000_0000;
    else
      count <= count + 32'h0000_0001;
  end
  assign tick = (count == 32'(CYCLES - 1));
endmodule // ms_tick

// ===== hw/gain_ramp.sv
`timescale 1ns/100ps
// linear blend old->new, value = old + (new-old)*step/total
module gain_ramp (
  input wire logic [15:0] old_value,
  input wire logic [15:0] new_value,
  input wire logic [15:0] step,
  input wire logic [15:0] total,
  output logic [15:0] value
);
  logic signed [17:0] diff;
  logic signed [34:0] prod;
  logic signed [34:0] quot;
  always_comb
  begin
    diff = 18'(signed'({2'b00, new_value})) - 18'(signed'({2'b00, old_value}));
    prod = 35'(diff) * 35'(signed'({19'h0_0000, step}));
    if (total == 16'h0000)
      quot = 35'(diff);
    else
      quot = prod / 35'(signed'({19'h0_0000, total}));
    value = 16'(35'(signed'({19'h0_0000, old_value})) + quot);
  end
endmodule // gain_ramp

// ===== hw/gain_set_switcher.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
// Summary of operation
// R1 - Automatic switching is on when the mode digit of the selection holds 2.
// R2 - Software must never write mode code 1, which is reserved.
// R3 - Automatic transitions happen only in position control.
// R4 - Condition A becoming true moves set 1 to set 2 with wait one and ramp one.
// R5 - Condition A becoming false moves set 2 to set 1 with wait two and ramp two.
// R6 - Code 0 means positioning done high, code 1 means positioning done low.
// R7 - Code 2 means near-target high, code 3 means near-target low.
// R8 - Code 4 means filter output zero with no reference, code 5 means reference present.
// R9 - Outside position control set 1 is used for codes 0,2,4 and set 2 for 1,3,5.
// R10 - After condition A changes, present gains are held for the wait time.
// R11 - During switching each gain moves linearly over the ramp time.
// R12 - All five gains of a set switch together.
// R13 - Model following gain and correction pass through untouched.
// R14 - Switching works for both PI and I-P speed loop structures.
// R15 - Times count in 1 ms units from 0 to 65535, default 0.
// R16 - A zero ramp time applies the new set in full at the first update after the wait.
module gain_set_switcher #(
  parameter int TICK_CYCLES = gain_switch_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic position_control,
  input wire logic positioning_done,
  input wire logic near_target,
  input wire logic ref_filter_zero,
  input wire logic ref_input_active,
  input wire logic speed_loop_structure_select,
  input wire logic [15:0] model_follow_gain_in,
  input wire logic [15:0] model_follow_corr_in,
  output logic [15:0] speed_loop_gain,
  output logic [15:0] speed_integral_time,
  output logic [15:0] position_loop_gain,
  output logic [15:0] torque_filter_time,
  output logic [15:0] friction_comp_gain,
  output logic [15:0] model_follow_gain,
  output logic [15:0] model_follow_corr,
  output logic speed_loop_structure,
  output logic gain_set_two_active,
  output logic switching_busy
);
  localparam int N = gain_switch_pkg::NUM_GAINS;

  typedef enum {ST_STEADY, ST_WAIT, ST_RAMP} sw_state_t;

  logic [15:0] gain_switch_select;
  logic [15:0] switch_wait_time_one;
  logic [15:0] switch_wait_time_two;
  logic [15:0] switch_ramp_time_one;
  logic [15:0] switch_ramp_time_two;
  logic [15:0] set_a [N];
  logic [15:0] set_b [N];
  logic [15:0] active [N];
  logic [15:0] start_val [N];
  logic [15:0] blend [N];
  logic [15:0] next_rdata;
  logic tick;
  logic auto_enable;
  logic cond_a;
  logic target_two;
  logic fixed_two;
  logic on_two;
  logic [15:0] timer;
  logic [15:0] wait_time;
  logic [15:0] ramp_time;
  logic [15:0] ramp_total;
  sw_state_t state;
  logic [2:0] cond_code;

  ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(tick)
  );

  assign cond_code = gain_switch_select[gain_switch_pkg::COND_LSB +: 3];
  assign auto_enable = (gain_switch_select[gain_switch_pkg::MODE_LSB +: 4]
    == gain_switch_pkg::MODE_AUTO); // R1

  always_comb
  begin
    case (cond_code)
      3'(gain_switch_pkg::COND_DONE_ON): cond_a = positioning_done; // R6
      3'(gain_switch_pkg::COND_DONE_OFF): cond_a = !positioning_done; // R6
      3'(gain_switch_pkg::COND_NEAR_ON): cond_a = near_target; // R7
      3'(gain_switch_pkg::COND_NEAR_OFF): cond_a = !near_target; // R7
      3'(gain_switch_pkg::COND_REF_IDLE): cond_a = ref_filter_zero && !ref_input_active; // R8
      3'(gain_switch_pkg::COND_REF_ACTIVE): cond_a = ref_input_active; // R8
      default: cond_a = 1'b0;
    endcase
  end

  // odd codes select set 2 outside position control
  assign fixed_two = cond_code[0]; // R9
  assign target_two = (position_control && auto_enable) ? cond_a : fixed_two; // R3 R4 R5
  assign wait_time = target_two ? switch_wait_time_one : switch_wait_time_two; // R4 R5
  assign ramp_time = target_two ? switch_ramp_time_one : switch_ramp_time_two; // R4 R5

  // register writes
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      gain_switch_select <= gain_switch_pkg::SELECTION_RESET;
      switch_wait_time_one <= gain_switch_pkg::TIME_RESET; // R15
      switch_wait_time_two <= gain_switch_pkg::TIME_RESET;
      switch_ramp_time_one <= gain_switch_pkg::TIME_RESET;
      switch_ramp_time_two <= gain_switch_pkg::TIME_RESET;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        gain_switch_pkg::GAIN_SWITCH_SELECTION_OFFSET: gain_switch_select <= reg_wdata;
        gain_switch_pkg::SWITCH_WAIT_ONE_OFFSET: switch_wait_time_one <= reg_wdata;
        gain_switch_pkg::SWITCH_WAIT_TWO_OFFSET: switch_wait_time_two <= reg_wdata;
        gain_switch_pkg::SWITCH_RAMP_ONE_OFFSET: switch_ramp_time_one <= reg_wdata;
        gain_switch_pkg::SWITCH_RAMP_TWO_OFFSET: switch_ramp_time_two <= reg_wdata;
        default: ;
      endcase
    end
  end

  // per-gain storage, blend and output
  for (genvar i = 0; i < N; i++)
  begin : g_gain
    always_ff @(posedge sys_clk or posedge reset)
    begin
      if (reset)
      begin
        set_a[i] <= gain_switch_pkg::GAIN_RESET[i];
        set_b[i] <= gain_switch_pkg::GAIN_RESET[i];
      end
      else if (reg_write && reg_addr == gain_switch_pkg::GAIN_SET_A_BASE + 16'(i))
        set_a[i] <= reg_wdata;
      else if (reg_write && reg_addr == gain_switch_pkg::GAIN_SET_B_BASE + 16'(i))
        set_b[i] <= reg_wdata;
    end

    gain_ramp u_ramp (
      .old_value(start_val[i]),
      .new_value(on_two ? set_b[i] : set_a[i]),
      .step(timer),
      .total(ramp_total),
      .value(blend[i])
    );

    always_ff @(posedge sys_clk or posedge reset)
    begin
      if (reset)
      begin
        active[i] <= gain_switch_pkg::GAIN_RESET[i];
        start_val[i] <= gain_switch_pkg::GAIN_RESET[i];
      end
      else if (state == ST_RAMP)
        active[i] <= blend[i]; // R11 R12
      else if (state == ST_STEADY)
      begin
        active[i] <= on_two ? set_b[i] : set_a[i]; // R12
        start_val[i] <= on_two ? set_b[i] : set_a[i];
      end
    end
  end

  // switching sequence: hold for wait, then ramp
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_STEADY;
      on_two <= 1'b0;
      timer <= 16'h0000;
      ramp_total <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_STEADY:
        begin
          timer <= 16'h0000;
          if (target_two != on_two)
            state <= ST_WAIT; // R10
        end
        ST_WAIT:
        begin
          if (target_two == on_two)
          begin
            state <= ST_STEADY;
            timer <= 16'h0000;
          end
          else if (timer >= wait_time)
          begin
            on_two <= target_two; // R4 R5
            ramp_total <= ramp_time;
            timer <= 16'h0000;
            state <= (ramp_time == 16'h0000) ? ST_STEADY : ST_RAMP; // R16
          end
          else if (tick)
            timer <= timer + 16'h0001; // R15
        end
        ST_RAMP:
        begin
          if (timer >= ramp_total)
            state <= ST_STEADY;
          else if (tick)
            timer <= timer + 16'h0001; // R11
        end
        default: state <= ST_STEADY;
      endcase
    end
  end

  assign model_follow_gain = model_follow_gain_in; // R13
  assign model_follow_corr = model_follow_corr_in; // R13
  assign speed_loop_structure = speed_loop_structure_select; // R14
  assign speed_loop_gain = active[0];
  assign speed_integral_time = active[1];
  assign position_loop_gain = active[2];
  assign torque_filter_time = active[3];
  assign friction_comp_gain = active[4];
  assign gain_set_two_active = on_two;
  assign switching_busy = (state != ST_STEADY);

  // read path
  always_comb
  begin
    next_rdata = 16'h0000;
    case (reg_addr)
      gain_switch_pkg::GAIN_SWITCH_SELECTION_OFFSET: next_rdata = gain_switch_select;
      gain_switch_pkg::SWITCH_WAIT_ONE_OFFSET: next_rdata = switch_wait_time_one;
      gain_switch_pkg::SWITCH_WAIT_TWO_OFFSET: next_rdata = switch_wait_time_two;
      gain_switch_pkg::SWITCH_RAMP_ONE_OFFSET: next_rdata = switch_ramp_time_one;
      gain_switch_pkg::SWITCH_RAMP_TWO_OFFSET: next_rdata = switch_ramp_time_two;
      gain_switch_pkg::ACTIVE_STATUS_OFFSET:
        next_rdata = {13'h0000, cond_a, switching_busy, on_two};
      default:
      begin
        for (int k = 0; k < N; k++)
        begin
          if (reg_addr == gain_switch_pkg::GAIN_SET_A_BASE + 16'(k))
            next_rdata = set_a[k];
          if (reg_addr == gain_switch_pkg::GAIN_SET_B_BASE + 16'(k))
            next_rdata = set_b[k];
          if (reg_addr == gain_switch_pkg::ACTIVE_GAIN_BASE + 16'(k))
            next_rdata = active[k];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 16'h0000;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 16'h0000;
  end

  sequence s_change;
    (target_two != on_two) && state == ST_STEADY;
  endsequence

  AST_NO_AUTO_OUTSIDE_POS: assert property (@(posedge sys_clk) disable iff (reset) // R3
    (!position_control && state == ST_STEADY) |=> on_two == $past(fixed_two) || switching_busy)
    else $error("gain set not fixed outside position control");
  AST_MODE_GATE: assert property (@(posedge sys_clk) disable iff (reset) // R1
    (!auto_enable || !position_control) |-> target_two == fixed_two)
    else $error("target not fixed when auto disabled");
  AST_START_WAIT: assert property (@(posedge sys_clk) disable iff (reset) // R10
    s_change |=> state == ST_WAIT && on_two == $past(on_two))
    else $error("wait not entered on condition change");
  AST_HOLD_DURING_WAIT: assert property (@(posedge sys_clk) disable iff (reset) // R10
    (state == ST_WAIT && $past(state) == ST_WAIT) |-> $stable(position_loop_gain))
    else $error("gains moved during wait");
  AST_ZERO_RAMP: assert property (@(posedge sys_clk) disable iff (reset) // R16
    (state == ST_WAIT && timer >= wait_time && target_two != on_two && ramp_time == 16'h0000)
    |=> ##1 position_loop_gain == (on_two ? set_b[2] : set_a[2]))
    else $error("zero ramp did not apply new set");
  AST_COND_DONE: assert property (@(posedge sys_clk) disable iff (reset) // R6
    cond_code == 3'h0 |-> cond_a == positioning_done)
    else $error("condition code 0 wrong");
  AST_COND_REF: assert property (@(posedge sys_clk) disable iff (reset) // R8
    cond_code == 3'h4 |-> cond_a == (ref_filter_zero && !ref_input_active))
    else $error("condition code 4 wrong");
  AST_RAMP_END: assert property (@(posedge sys_clk) disable iff (reset) // R11
    (state == ST_RAMP && timer >= ramp_total) |=> ##1
    speed_loop_gain == (on_two ? set_b[0] : set_a[0]) || state != ST_STEADY)
    else $error("ramp did not end at new value");
  AST_MF_PASS: assert property (@(posedge sys_clk) disable iff (reset) // R13
    model_follow_gain == model_follow_gain_in && model_follow_corr == model_follow_corr_in)
    else $error("model following values altered");
endmodule // gain_set_switcher

// ===== bench/loop_model.sv
`timescale 1ns/100ps
module loop_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic move,
  output logic positioning_done,
  output logic near_target,
  output logic ref_filter_zero,
  output logic ref_input_active
);
  logic [2:0] settle;
  // cycles since the reference stopped
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      settle <= 3'h0;
    else if (move)
      settle <= 3'h0;
    else if (settle != 3'h7)
      settle <= settle + 3'h1;
  end
  assign ref_input_active = move;
  assign ref_filter_zero = !move && settle >= 3'h1;
  assign near_target = !move && settle >= 3'h2;
  assign positioning_done = !move && settle >= 3'h4;
endmodule // loop_model

// ===== bench/gain_set_switcher_bench.sv
`timescale 1ns/100ps
module gain_set_switcher_bench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, mf_g = 16'h0000;
  logic [15:0] mf_c = 16'h0000, mf_g_o, mf_c_o, seed = 16'h0006;
  logic reg_write = 1'b0, reg_read = 1'b0, position_control = 1'b0, move = 1'b1;
  logic struct_sel = 1'b0, struct_o, two, busy, done, near, fzero, refon;
  logic [15:0] gain [5];
  logic [15:0] set_a [5];
  logic [15:0] set_b [5];
  int mismatches = 0;
  int checks_done = 0;

  always #12.5 sys_clk = ~sys_clk;

  gain_set_switcher #(.TICK_CYCLES(4)) gain_set_switcher_i (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .position_control(position_control), .positioning_done(done),
    .near_target(near), .ref_filter_zero(fzero), .ref_input_active(refon),
    .speed_loop_structure_select(struct_sel), .model_follow_gain_in(mf_g),
    .model_follow_corr_in(mf_c), .speed_loop_gain(gain[0]), .speed_integral_time(gain[1]),
    .position_loop_gain(gain[2]), .torque_filter_time(gain[3]), .friction_comp_gain(gain[4]),
    .model_follow_gain(mf_g_o), .model_follow_corr(mf_c_o), .speed_loop_structure(struct_o),
    .gain_set_two_active(two), .switching_busy(busy));

  loop_model loop_model_i (.sys_clk(sys_clk), .reset(reset), .move(move),
    .positioning_done(done), .near_target(near), .ref_filter_zero(fzero),
    .ref_input_active(refon));

  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction

  function automatic logic cond_of(input logic [2:0] c);
    case (c)
      3'h0: return done;
      3'h1: return !done;
      3'h2: return near;
      3'h3: return !near;
      3'h4: return fzero && !refon;
      default: return refon;
    endcase
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_set(input logic on_two);
    chk("set two", {15'h0000, two}, {15'h0000, on_two});
    for (int i = 0; i < 5; i++)
      chk("active gain", gain[i], on_two ? set_b[i] : set_a[i]);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    chk("read data", reg_rdata, exp);
    @(negedge sys_clk);
    chk("read idle", reg_rdata, 16'h0000);
  endtask

  task automatic sel(input logic [2:0] code, input logic [3:0] mode);
    wr(gain_switch_pkg::GAIN_SWITCH_SELECTION_OFFSET, {9'h000, code, mode});
  endtask

  task automatic times(input logic [15:0] w1, w2, r1, r2);
    wr(gain_switch_pkg::SWITCH_WAIT_ONE_OFFSET, w1);
    wr(gain_switch_pkg::SWITCH_WAIT_TWO_OFFSET, w2);
    wr(gain_switch_pkg::SWITCH_RAMP_ONE_OFFSET, r1);
    wr(gain_switch_pkg::SWITCH_RAMP_TWO_OFFSET, r2);
  endtask

  task automatic wait_idle();
    repeat (200) if (busy === 1'b1) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("busy", {15'h0000, busy}, 16'h0000);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    logic [15:0] v;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      chk("reset gain", gain[i], gain_switch_pkg::GAIN_RESET[i]);
      rdc(gain_switch_pkg::GAIN_SET_B_BASE + 16'(i), gain_switch_pkg::GAIN_RESET[i]);
      set_a[i] = rnd();
      set_b[i] = rnd();
      wr(gain_switch_pkg::GAIN_SET_A_BASE + 16'(i), set_a[i]);
      wr(gain_switch_pkg::GAIN_SET_B_BASE + 16'(i), set_b[i]);
    end
    rdc(gain_switch_pkg::SWITCH_WAIT_ONE_OFFSET, 16'h0000);
    rdc(16'h2300, 16'h0000);
    wr(gain_switch_pkg::SWITCH_RAMP_ONE_OFFSET, 16'hffff);
    rdc(gain_switch_pkg::SWITCH_RAMP_ONE_OFFSET, 16'hffff);
    times(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    $display("test registers done");
    // fixed sets: manual mode, then auto mode outside position control
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 6; c++)
      begin
        v = rnd();
        sel(3'(c), m == 1 ? gain_switch_pkg::MODE_AUTO : 4'h0);
        position_control <= m == 1 ? 1'b0 : v[0];
        move <= v[1];
        cyc(10);
        chk_set(c % 2 == 1);
      end
    $display("test fixed sets done");
    @(posedge sys_clk) position_control <= 1'b1;
    for (int c = 0; c < 6; c++)
    begin
      sel(3'(c), gain_switch_pkg::MODE_AUTO);
      for (int mv = 0; mv < 2; mv++)
      begin
        @(posedge sys_clk) move <= mv[0];
        cyc(12);
        chk_set(cond_of(3'(c)));
      end
    end
    $display("test condition codes done");
    sel(3'h0, gain_switch_pkg::MODE_AUTO);
    times(16'h0003, 16'h0001, 16'h0002, 16'h0004);
    cyc(6);
    chk_set(1'b0);
    @(posedge sys_clk) move <= 1'b0;
    repeat (10) if (done !== 1'b1) @(posedge sys_clk);
    cyc(6);
    chk_set(1'b0);
    chk("busy wait", {15'h0000, busy}, 16'h0001);
    wait_idle();
    chk_set(1'b1);
    rdc(gain_switch_pkg::ACTIVE_GAIN_BASE + 16'h0002, set_b[2]);
    rdc(gain_switch_pkg::ACTIVE_STATUS_OFFSET, 16'h0005);
    @(posedge sys_clk) move <= 1'b1;
    cyc(2);
    wait_idle();
    chk_set(1'b0);
    $display("test timed switch done");
    for (int k = 0; k < 4; k++)
    begin
      v = rnd();
      @(posedge sys_clk);
      mf_g <= v;
      mf_c <= ~v;
      struct_sel <= v[0];
      cyc(0);
      chk("model gain", mf_g_o, v);
      chk("model corr", mf_c_o, ~v);
      chk("structure", {15'h0000, struct_o}, {15'h0000, v[0]});
    end
    $display("test pass through done");
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
endmodule // gain_set_switcher_bench
